// ---- common/sac_if.sv ----
// Purpose: Pin bundle between converter and bus host
// Assumes: Host drives control pins, converter drives data and status
// Notes:   Data bus not resolved from data_oe; the host samples data_out directly
`timescale 1ns/1ps
interface sac_if;
   logic        cs_n;
   logic        rd_n;
   logic        convert_start_n;
   logic        high_byte_select;
   logic        sleep_n;
   logic        nap_n;
   logic [11:0] data_out;
   logic        data_oe;
   logic        busy_n;
   logic        reference_ready_flag;

   modport dev (
      input  cs_n, rd_n, convert_start_n, high_byte_select, sleep_n, nap_n,
      output data_out, data_oe, busy_n, reference_ready_flag
   );
   modport host (
      output cs_n, rd_n, convert_start_n, high_byte_select, sleep_n, nap_n,
      input  data_out, data_oe, busy_n, reference_ready_flag
   );
endinterface

// ---- common/sac_pkg.sv ----
// Purpose: Shared constants and types for the sampling converter control ends
// Assumes: sys_clk at 50 MHz
// Notes:   Times kept in their own unit, cycle counts derived from them
package sac_pkg;
   localparam int unsigned CLK_MHZ          = 50;
   localparam int unsigned CONV_TIME_NS     = 6000;
   localparam int unsigned ACQ_TIME_NS      = 2000;
   localparam int unsigned WAKE_TIME_US     = 3000;
   localparam int unsigned NAP_WAKE_NS      = 620;
   localparam int unsigned CONV_CYCLES      = (CONV_TIME_NS * CLK_MHZ) / 1000;
   localparam int unsigned ACQ_CYCLES       = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WAKE_CYCLES      = WAKE_TIME_US * CLK_MHZ;
   localparam int unsigned NAP_WAKE_CYCLES  = (NAP_WAKE_NS * CLK_MHZ) / 1000;
   localparam int unsigned RESULT_W         = 12;
   localparam int unsigned BYTE_W           = 8;
   localparam int unsigned CNT_W            = 24;
   localparam logic [11:0] RESULT_RST       = 12'h000;
   localparam logic [11:0] SIGN_FLIP        = 12'h800;
   localparam logic [2:0]  SYNC_RST         = 3'h7;

   typedef enum logic [1:0] {
      SAC_IDLE = 2'b00,
      SAC_CONV = 2'b01,
      SAC_WAKE = 2'b10,
      SAC_NAP  = 2'b11
   } sac_state_t;

   typedef enum logic [1:0] {
      SAC_MODE_ALWAYS = 2'b00,
      SAC_MODE_STROBE = 2'b01,
      SAC_MODE_SLOW   = 2'b10,
      SAC_MODE_ROM    = 2'b11
   } sac_mode_t;
endpackage

// ---- verif/sac_monitor.sv ----
// Purpose: Pin-level assertions between the host and converter ends
// Assumes: One clock domain, async active low reset
// Notes:   Helper counters time the busy span and the awake span
`timescale 1ns/1ps
module sac_monitor #(
   parameter int unsigned WAKE_CYCLES = 20
) (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rst_b,
   // Host driven pins
   input wire logic        cs_n,
   input wire logic        rd_n,
   input wire logic        convert_start_n,
   input wire logic        high_byte_select,
   input wire logic        sleep_n,
   input wire logic        nap_n,
   // Converter driven pins
   input wire logic [11:0] data_out,
   input wire logic        data_oe,
   input wire logic        busy_n,
   input wire logic        reference_ready_flag
);
   localparam int WAKE_HI = WAKE_CYCLES + 16;
   logic [15:0] lo_cnt_ff;
   logic [15:0] wake_cnt_ff;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_start;
      $fell(busy_n);
   endsequence
   sequence s_done;
      $rose(busy_n);
   endsequence

   // Cycles spent busy
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lo_cnt_ff <= 16'h0000;
      end else if (busy_n) begin
         lo_cnt_ff <= 16'h0000;
      end else begin
         lo_cnt_ff <= lo_cnt_ff + 16'h0001;
      end
   end

   // Cycles awake since sleep released
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_cnt_ff <= 16'h0000;
      end else if (!sleep_n) begin
         wake_cnt_ff <= 16'h0000;
      end else if (wake_cnt_ff != 16'hFFFF) begin
         wake_cnt_ff <= wake_cnt_ff + 16'h0001;
      end
   end

   AST_BUSY_LEN: assert property (s_done |->
      lo_cnt_ff == sac_pkg::CONV_CYCLES)
      else $error("busy low span wrong length");
   AST_START_SEL: assert property (s_start |-> !cs_n && sleep_n)
      else $error("conversion began without select or in sleep");
   AST_START_READY: assert property (s_start |-> reference_ready_flag)
      else $error("conversion began before reference ready");
   AST_NO_RESTART: assert property (s_done |=> busy_n[*2])
      else $error("conversion restarted at once");
   AST_OE_READ: assert property ((cs_n | rd_n)[*8] |-> !data_oe)
      else $error("data driven without select and read");
   AST_SLEEP_DOWN: assert property (!sleep_n[*8] |->
      !reference_ready_flag && busy_n)
      else $error("device active in sleep");
   AST_WAKE_MIN: assert property ($rose(reference_ready_flag) |->
      wake_cnt_ff >= WAKE_CYCLES)
      else $error("reference ready too early");
   AST_WAKE_BOUND: assert property ($rose(sleep_n) |->
      ##[1:WAKE_HI] reference_ready_flag)
      else $error("reference ready too late");
   AST_DATA_HOLD: assert property (s_start ##0 data_oe |->
      ##1 $stable(data_out)[*8])
      else $error("previous result not held at conversion start");
endmodule

// ---- verif/sampling_adc_conversion_control_tb.sv ----
// Purpose: Drives the host user side and checks results from the converter
// Assumes: sys_clk 50 MHz, WAKE_CYCLES shortened to 20
// Notes:   Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
module sampling_adc_conversion_control_tb;
   logic               sys_clk;
   logic               rst_b;
   logic               byte_wide;
   logic               bipolar;
   logic [11:0]        sample_in;
   sac_pkg::sac_mode_t mode;
   logic               go;
   logic               high_pulse;
   logic               high_byte;
   logic               sleep_req;
   logic               nap_req;
   logic               ready_ff;
   logic               done_ff;
   logic [11:0]        rdata_ff;
   logic               comp_on;
   logic               conv_done;
   int                 n_errors;
   int                 checks;

   sac_if bus ();
   sac_device #(.WAKE_CYCLES(20)) sac_device_inst (.sys_clk(sys_clk), .rst_b(rst_b),
      .pins(bus.dev), .byte_wide(byte_wide), .bipolar(bipolar), .sample_in(sample_in),
      .comparator_on_ff(comp_on), .conv_done_ff(conv_done));
   sac_host sac_host_inst (.sys_clk(sys_clk), .rst_b(rst_b), .pins(bus.host), .mode(mode),
      .go(go), .high_pulse(high_pulse), .high_byte(high_byte), .sleep_req(sleep_req),
      .nap_req(nap_req), .ready_ff(ready_ff), .done_ff(done_ff), .rdata_ff(rdata_ff));
   sac_monitor #(.WAKE_CYCLES(20)) sac_monitor_inst (.sys_clk(sys_clk), .rst_b(rst_b),
      .cs_n(bus.cs_n), .rd_n(bus.rd_n), .convert_start_n(bus.convert_start_n),
      .high_byte_select(bus.high_byte_select), .sleep_n(bus.sleep_n), .nap_n(bus.nap_n),
      .data_out(bus.data_out), .data_oe(bus.data_oe), .busy_n(bus.busy_n),
      .reference_ready_flag(bus.reference_ready_flag));

   task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done();
      if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // One host transfer, bounded waits on ready and done
   task automatic xfer(input sac_pkg::sac_mode_t m, input logic hp, input logic hb,
                       input logic [11:0] s);
      int k;
      @(posedge sys_clk);
      mode <= m;
      high_pulse <= hp;
      high_byte <= hb;
      sample_in <= s;
      // High idle start level must stand before go, or no falling edge is seen
      if (!hp) begin
         repeat (6) @(posedge sys_clk);
      end
      k = 0;
      while (ready_ff !== 1'b1 && k < 1000) begin
         @(posedge sys_clk);
         k++;
      end
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      k = 0;
      while (done_ff !== 1'b1 && k < 1000) begin
         @(posedge sys_clk);
         k++;
      end
      chk("done", {11'h000, done_ff}, 12'h001);
   endtask

   task automatic t_reset();
      chk("busy_n", {11'h000, bus.busy_n}, 12'h001);
      chk("data_oe", {11'h000, bus.data_oe}, 12'h000);
      chk("comp_rst", {11'h000, comp_on}, 12'h001);
   endtask

   task automatic t_busy();
      int n;
      xfer(sac_pkg::SAC_MODE_STROBE, 1'b0, 1'b0, 12'hA5C);
      chk("strobe", rdata_ff, 12'hA5C);
      repeat (12) @(posedge sys_clk);
      chk("oe_idle", {11'h000, bus.data_oe}, 12'h000);
      @(posedge sys_clk);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      n = 0;
      while (bus.busy_n !== 1'b0 && n < 50) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      n = 0;
      while (bus.busy_n === 1'b0 && n < 1000) begin
         n++;
         @(posedge sys_clk);
         #1;
      end
      chk("busy_len", n[11:0], 12'(sac_pkg::CONV_CYCLES));
      chk("conv_done", {11'h000, conv_done}, 12'h001);
      repeat (20) @(posedge sys_clk);
   endtask

   task automatic t_modes();
      xfer(sac_pkg::SAC_MODE_ALWAYS, 1'b0, 1'b0, 12'h3C1);
      chk("always_lo", rdata_ff, 12'h3C1);
      xfer(sac_pkg::SAC_MODE_ALWAYS, 1'b1, 1'b0, 12'hFFF);
      chk("always_hi", rdata_ff, 12'hFFF);
      xfer(sac_pkg::SAC_MODE_SLOW, 1'b0, 1'b0, 12'h000);
      chk("slow", rdata_ff, 12'h000);
      xfer(sac_pkg::SAC_MODE_ROM, 1'b0, 1'b0, 12'h6E9);
      chk("rom", rdata_ff, 12'h6E9);
   endtask

   task automatic t_byte();
      byte_wide <= 1'b1;
      xfer(sac_pkg::SAC_MODE_STROBE, 1'b0, 1'b1, 12'hB7E);
      chk("byte_hi", rdata_ff, 12'h00B);
      xfer(sac_pkg::SAC_MODE_STROBE, 1'b0, 1'b0, 12'hB7E);
      chk("byte_lo", rdata_ff, 12'h07E);
      bipolar <= 1'b1;
      xfer(sac_pkg::SAC_MODE_STROBE, 1'b0, 1'b1, 12'h123);
      chk("bip_byte", rdata_ff, 12'h009);
      byte_wide <= 1'b0;
      xfer(sac_pkg::SAC_MODE_STROBE, 1'b0, 1'b0, 12'h923);
      chk("bip_word", rdata_ff, 12'h923);
      bipolar <= 1'b0;
   endtask

   task automatic t_power();
      sleep_req <= 1'b1;
      repeat (12) @(posedge sys_clk);
      chk("ref_sleep", {11'h000, bus.reference_ready_flag}, 12'h000);
      chk("comp_sleep", {11'h000, comp_on}, 12'h000);
      sleep_req <= 1'b0;
      repeat (40) @(posedge sys_clk);
      chk("ref_wake", {11'h000, bus.reference_ready_flag}, 12'h001);
      chk("comp_wake", {11'h000, comp_on}, 12'h001);
      byte_wide <= 1'b1;
      nap_req <= 1'b1;
      repeat (12) @(posedge sys_clk);
      chk("comp_nap", {11'h000, comp_on}, 12'h000);
      nap_req <= 1'b0;
      xfer(sac_pkg::SAC_MODE_STROBE, 1'b0, 1'b0, 12'h45A);
      chk("nap_wake", rdata_ff, 12'h05A);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      test_done();
   end

   initial begin
      n_errors = 0;
      checks = 0;
      rst_b = 1'b0;
      byte_wide = 1'b0;
      bipolar = 1'b0;
      sample_in = 12'h000;
      mode = sac_pkg::SAC_MODE_STROBE;
      go = 1'b0;
      high_pulse = 1'b0;
      high_byte = 1'b0;
      sleep_req = 1'b0;
      nap_req = 1'b0;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      t_reset();
      t_busy();
      t_modes();
      t_byte();
      t_power();
      test_done();
   end
endmodule

// ---- verilog/sac_device.sv ----
// Purpose: Converter end: start, busy, result latch, read drive, power states
// Assumes: Pins from the host are asynchronous and pass three flip-flops
// Notes:   The analog result arrives on sample_in and is taken at conversion end
`timescale 1ns/1ps
module sac_device #(
   parameter int unsigned WAKE_CYCLES = sac_pkg::WAKE_CYCLES
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   // Pins
   sac_if.dev               pins,
   // User side
   input  wire logic        byte_wide,
   input  wire logic        bipolar,
   input  wire logic [11:0] sample_in,
   output logic             comparator_on_ff,
   output logic             conv_done_ff
);
   logic [2:0]          cs_sync_ff;
   logic [2:0]          rd_sync_ff;
   logic [2:0]          cv_sync_ff;
   logic [2:0]          sl_sync_ff;
   logic [2:0]          np_sync_ff;
   logic [2:0]          hb_sync_ff;
   logic                cs_n_ff;
   logic                rd_n_ff;
   logic                cv_n_ff;
   logic                sl_n_ff;
   logic                np_n_ff;
   logic                hb_ff;
   logic                cv_prev_ff;
   logic                sl_prev_ff;
   sac_pkg::sac_state_t state_ff;
   logic [sac_pkg::CNT_W-1:0] cnt_ff;
   logic [11:0]         result_ff;
   logic                busy_n_ff;
   logic                ready_ff;
   logic                data_oe_ff;
   logic [11:0]         data_out_ff;
   logic                start_req;
   logic [11:0]         coded;

   // Two later stages agree before a change counts
   function automatic logic filt(input logic [2:0] s, input logic cur);
      filt = (s[2] == s[1]) ? s[1] : cur;
   endfunction

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cs_sync_ff <= sac_pkg::SYNC_RST;
         rd_sync_ff <= sac_pkg::SYNC_RST;
         cv_sync_ff <= sac_pkg::SYNC_RST;
         sl_sync_ff <= sac_pkg::SYNC_RST;
         np_sync_ff <= sac_pkg::SYNC_RST;
         hb_sync_ff <= 3'h0;
         cs_n_ff    <= 1'b1;
         rd_n_ff    <= 1'b1;
         cv_n_ff    <= 1'b1;
         sl_n_ff    <= 1'b1;
         np_n_ff    <= 1'b1;
         hb_ff      <= 1'b0;
      end else begin
         cs_sync_ff <= {cs_sync_ff[1:0], pins.cs_n};
         rd_sync_ff <= {rd_sync_ff[1:0], pins.rd_n};
         cv_sync_ff <= {cv_sync_ff[1:0], pins.convert_start_n};
         sl_sync_ff <= {sl_sync_ff[1:0], pins.sleep_n};
         np_sync_ff <= {np_sync_ff[1:0], pins.nap_n};
         hb_sync_ff <= {hb_sync_ff[1:0], pins.high_byte_select};
         cs_n_ff    <= filt(cs_sync_ff, cs_n_ff);
         rd_n_ff    <= filt(rd_sync_ff, rd_n_ff);
         cv_n_ff    <= filt(cv_sync_ff, cv_n_ff);
         sl_n_ff    <= filt(sl_sync_ff, sl_n_ff);
         np_n_ff    <= filt(np_sync_ff, np_n_ff);
         hb_ff      <= filt(hb_sync_ff, hb_ff);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cv_prev_ff <= 1'b1;
         sl_prev_ff <= 1'b1;
      end else begin
         cv_prev_ff <= cv_n_ff;
         sl_prev_ff <= sl_n_ff;
      end
   end

   // Falling start edge qualified by select; low and high pulses both fall
   assign start_req = cv_prev_ff && !cv_n_ff && !cs_n_ff;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff  <= sac_pkg::SAC_IDLE;
         cnt_ff    <= '0;
         busy_n_ff <= 1'b1;
         ready_ff  <= 1'b1;
      end else begin
         case (state_ff)
            sac_pkg::SAC_IDLE: begin
               if (!sl_n_ff) begin
                  ready_ff <= 1'b0;
                  state_ff <= sac_pkg::SAC_WAKE;
                  cnt_ff   <= '0;
               end else if (!np_n_ff && byte_wide) begin
                  state_ff <= sac_pkg::SAC_NAP;
               end else if (start_req && ready_ff) begin
                  busy_n_ff <= 1'b0;
                  state_ff  <= sac_pkg::SAC_CONV;
                  cnt_ff    <= '0;
               end
            end
            sac_pkg::SAC_CONV: begin
               // Further start edges have no path here
               if (cnt_ff == sac_pkg::CNT_W'(sac_pkg::CONV_CYCLES - 1)) begin
                  busy_n_ff <= 1'b1;
                  state_ff  <= sac_pkg::SAC_IDLE;
               end else begin
                  cnt_ff <= cnt_ff + 1'b1;
               end
            end
            sac_pkg::SAC_WAKE: begin
               if (!sl_n_ff) begin
                  cnt_ff <= '0;
               end else if (cnt_ff == sac_pkg::CNT_W'(WAKE_CYCLES - 1)) begin
                  ready_ff <= 1'b1;
                  state_ff <= sac_pkg::SAC_IDLE;
               end else begin
                  cnt_ff <= cnt_ff + 1'b1;
               end
            end
            sac_pkg::SAC_NAP: begin
               if (!sl_n_ff) begin
                  ready_ff <= 1'b0;
                  state_ff <= sac_pkg::SAC_WAKE;
                  cnt_ff   <= '0;
               end else if (np_n_ff) begin
                  state_ff <= sac_pkg::SAC_IDLE;
               end
            end
            default: begin
               state_ff <= sac_pkg::SAC_IDLE;
            end
         endcase
      end
   end

   // Comparator powered outside sleep and nap, including during the wake count
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         comparator_on_ff <= 1'b1;
      end else begin
         comparator_on_ff <= sl_n_ff && (np_n_ff || !byte_wide)
                             && state_ff != sac_pkg::SAC_NAP;
      end
   end

   // Bipolar coding differs by variant; unipolar is straight binary
   always_comb begin
      coded = sample_in;
      if (bipolar && byte_wide) begin
         coded = sample_in ^ sac_pkg::SIGN_FLIP;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         result_ff    <= sac_pkg::RESULT_RST;
         conv_done_ff <= 1'b0;
      end else begin
         conv_done_ff <= 1'b0;
         if (state_ff == sac_pkg::SAC_CONV
             && cnt_ff == sac_pkg::CNT_W'(sac_pkg::CONV_CYCLES - 1)) begin
            result_ff    <= coded;
            conv_done_ff <= 1'b1;
         end
      end
   end

   // Drive only with select and read low; old result until the latch loads
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         data_oe_ff  <= 1'b0;
         data_out_ff <= 12'h000;
      end else begin
         data_oe_ff <= !cs_n_ff && !rd_n_ff;
         if (byte_wide) begin
            data_out_ff <= hb_ff ? {8'h00, result_ff[11:8]} :
                           {4'h0, result_ff[7:0]};
         end else begin
            data_out_ff <= result_ff;
         end
      end
   end

   assign pins.data_out             = data_out_ff;
   assign pins.data_oe              = data_oe_ff;
   assign pins.busy_n               = busy_n_ff;
   assign pins.reference_ready_flag = ready_ff;
endmodule

// ---- verilog/sac_host.sv ----
// Purpose: Bus host end: starts conversions and reads results in four modes
// Assumes: Same sys_clk domain as device in the bench; pins are asynchronous
// Notes:   One request per go pulse; result reported on done pulse
`timescale 1ns/1ps
module sac_host (
   // Clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rst_b,
   // Pins
   sac_if.host                      pins,
   // User side
   input  wire sac_pkg::sac_mode_t  mode,
   input  wire logic                go,
   input  wire logic                high_pulse,
   input  wire logic                high_byte,
   input  wire logic                sleep_req,
   input  wire logic                nap_req,
   output logic                     ready_ff,
   output logic                     done_ff,
   output logic [11:0]              rdata_ff
);
   typedef enum logic [1:0] {
      SAC_H_IDLE  = 2'b00,
      SAC_H_PULSE = 2'b01,
      SAC_H_WAIT  = 2'b10,
      SAC_H_READ  = 2'b11
   } sac_hstate_t;

   sac_hstate_t state_ff;
   logic [2:0]  busy_sync_ff;
   logic        busy_n_ff;
   logic        busy_prev_ff;
   logic        cs_n_ff;
   logic        rd_n_ff;
   logic        cv_n_ff;
   logic [3:0]  cnt_ff;
   logic        hb_sel_ff;
   logic        sleep_n_ff;
   logic        nap_n_ff;

   // Level pins registered so every pin leaves a flip-flop
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         hb_sel_ff  <= 1'b0;
         sleep_n_ff <= 1'b1;
         nap_n_ff   <= 1'b1;
      end else begin
         hb_sel_ff  <= high_byte;
         sleep_n_ff <= !sleep_req;
         nap_n_ff   <= !nap_req;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_sync_ff <= sac_pkg::SYNC_RST;
         busy_n_ff    <= 1'b1;
         busy_prev_ff <= 1'b1;
      end else begin
         busy_sync_ff <= {busy_sync_ff[1:0], pins.busy_n};
         if (busy_sync_ff[2] == busy_sync_ff[1]) begin
            busy_n_ff <= busy_sync_ff[1];
         end
         busy_prev_ff <= busy_n_ff;
      end
   end

   // Idle pin levels depend on mode; joined pins share rd_n and start
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= SAC_H_IDLE;
         cs_n_ff  <= 1'b1;
         rd_n_ff  <= 1'b1;
         cv_n_ff  <= 1'b1;
         cnt_ff   <= 4'h0;
         done_ff  <= 1'b0;
         rdata_ff <= 12'h000;
         ready_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         case (state_ff)
            SAC_H_IDLE: begin
               ready_ff <= 1'b1;
               cs_n_ff  <= (mode == sac_pkg::SAC_MODE_ALWAYS) ? 1'b0 : cs_n_ff;
               rd_n_ff  <= (mode == sac_pkg::SAC_MODE_ALWAYS) ? 1'b0 : 1'b1;
               cv_n_ff  <= (mode == sac_pkg::SAC_MODE_ALWAYS) ? !high_pulse : 1'b1;
               if (go) begin
                  ready_ff <= 1'b0;
                  cs_n_ff  <= 1'b0;
                  cnt_ff   <= 4'h0;
                  state_ff <= SAC_H_PULSE;
                  if (mode == sac_pkg::SAC_MODE_ALWAYS && high_pulse) begin
                     cv_n_ff <= 1'b1;
                  end else begin
                     cv_n_ff <= 1'b0;
                  end
                  if (mode == sac_pkg::SAC_MODE_SLOW || mode == sac_pkg::SAC_MODE_ROM) begin
                     rd_n_ff <= 1'b0;
                  end
               end
            end
            SAC_H_PULSE: begin
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'h7) begin
                  if (mode == sac_pkg::SAC_MODE_ROM) begin
                     rdata_ff <= pins.data_out;
                     rd_n_ff  <= 1'b1;
                     cv_n_ff  <= 1'b1;
                  end else if (mode != sac_pkg::SAC_MODE_SLOW) begin
                     cv_n_ff <= !(mode == sac_pkg::SAC_MODE_ALWAYS && high_pulse);
                  end
                  state_ff <= SAC_H_WAIT;
               end
            end
            SAC_H_WAIT: begin
               // In strobe and ROM modes, hold off the bus until busy returns high
               if (!busy_prev_ff && busy_n_ff) begin
                  state_ff <= SAC_H_READ;
                  cnt_ff   <= 4'h0;
                  rd_n_ff  <= 1'b0;
               end
            end
            SAC_H_READ: begin
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == 4'h7) begin
                  rdata_ff <= pins.data_out;
                  done_ff  <= 1'b1;
                  rd_n_ff  <= 1'b1;
                  cv_n_ff  <= 1'b1;
                  state_ff <= SAC_H_IDLE;
               end
            end
            default: begin
               state_ff <= SAC_H_IDLE;
            end
         endcase
      end
   end

   assign pins.cs_n             = cs_n_ff;
   assign pins.rd_n             = rd_n_ff;
   assign pins.convert_start_n  = cv_n_ff;
   assign pins.high_byte_select = hb_sel_ff;
   assign pins.sleep_n          = sleep_n_ff;
   assign pins.nap_n            = nap_n_ff;
endmodule
